// ### rtl/cbwd_decode.sv
// The address-and-strobe port was decided locally.
`timescale 1ns/10ps
// Window registers and forwarding decode for one socket function.
// Two independent lookups: one for host-side cycles heading to the card,
// one for card-side cycles heading to the host.
// Both lookups see the registers as they stood before a same-edge write,
// so a window retuned under traffic takes effect one cycle later.
// Window 0 wins where the two windows overlap; the answer names one window.
// The I/O compare uses all 32 address bits, so an I/O cycle outside the
// first 64-kbyte page never hits, whatever the window holds.
// A low clock enable freezes registers and answers alike; a strobe seen
// on a frozen edge is lost, not deferred.
module cbwd_decode
  import cbwd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire cbwd_req_t req,
  output logic [31:0] rdata,
  input wire logic [31:0] host_addr,
  input wire logic host_is_io,
  input wire logic host_valid,
  output cbwd_hit_t host_hit,
  input wire logic [31:0] card_addr,
  input wire logic card_is_io,
  input wire logic card_valid,
  output cbwd_hit_t card_hit
);
  logic [31:0] mem_bot_ff [2];
  logic [31:0] mem_top_ff [2];
  logic [31:0] io_bot_ff [2];
  logic [31:0] io_top_ff [2];
  logic [7:0] irq_scr_ff;
  logic [1:0] win_type_ff;
  logic [31:0] rdata_ff;
  cbwd_hit_t host_hit_ff;
  cbwd_hit_t card_hit_ff;

  logic [31:0] nxt_rdata;
  logic [31:0] wmem;
  logic [31:0] wio;
  logic [1:0] h_mem;
  logic [1:0] h_io;
  logic [1:0] c_mem;
  logic [1:0] c_io;
  cbwd_hit_t nxt_host_hit;
  cbwd_hit_t nxt_card_hit;
  cbwd_win_t mem_win [2];
  cbwd_win_t io_win [2];

  // Register selects and gated strobes
  logic wr_go;
  logic rd_go;
  logic sel_mem_bot0;
  logic sel_mem_top0;
  logic sel_mem_bot1;
  logic sel_mem_top1;
  logic sel_io_bot0;
  logic sel_io_top0;
  logic sel_io_bot1;
  logic sel_io_top1;
  logic sel_irq_scr;
  logic sel_win_type;
  // Per-register write enables
  logic we_mem_bot0;
  logic we_mem_top0;
  logic we_mem_bot1;
  logic we_mem_top1;
  logic we_io_bot0;
  logic we_io_top0;
  logic we_io_bot1;
  logic we_io_top1;
  logic we_irq_scr;
  logic we_win_type;
  logic [31:0] scr_word;
  logic [31:0] type_word;

  // Write data trimmed to writable bits; read-only bits never stored
  assign wmem = req.wdata & CBWD_MEM_MASK;
  assign wio = req.wdata & CBWD_IO_MASK;

  // Combine a window pair into one answer; window 0 wins an overlap
  function automatic cbwd_hit_t pick(input logic [1:0] m,
                                     input logic [1:0] i,
                                     input logic is_io,
                                     input logic valid,
                                     input logic [1:0] pf);
    cbwd_hit_t h;
    h = '0;
    if (valid && !is_io && (m != 2'h0)) begin
      h.mem_hit = 1'b1;
      h.mem_win = !m[0];
      h.prefetch = m[0] ? pf[CBWD_TYPE_W0] : pf[CBWD_TYPE_W1];
    end
    if (valid && is_io && (i != 2'h0)) begin
      h.io_hit = 1'b1;
      h.io_win = !i[0];
    end
    return h;
  endfunction

  // Compare each window against both address sources
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_win
      assign mem_win[g] = '{bottom: mem_bot_ff[g], top: mem_top_ff[g]};
      assign io_win[g] = '{bottom: io_bot_ff[g], top: io_top_ff[g]};
      cbwd_range_cmp u_hmem (
        .win(mem_win[g]),
        .low_ones(CBWD_MEM_LOW_ONES),
        .addr(host_addr),
        .hit(h_mem[g])
      );
      cbwd_range_cmp u_cmem (
        .win(mem_win[g]),
        .low_ones(CBWD_MEM_LOW_ONES),
        .addr(card_addr),
        .hit(c_mem[g])
      );
      cbwd_range_cmp u_hio (
        .win(io_win[g]),
        .low_ones(CBWD_IO_LOW_ONES),
        .addr(host_addr),
        .hit(h_io[g])
      );
      cbwd_range_cmp u_cio (
        .win(io_win[g]),
        .low_ones(CBWD_IO_LOW_ONES),
        .addr(card_addr),
        .hit(c_io[g])
      );
    end
  endgenerate

  assign nxt_host_hit = pick(h_mem, h_io, host_is_io, host_valid,
                             win_type_ff);
  assign nxt_card_hit = pick(c_mem, c_io, card_is_io, card_valid,
                             win_type_ff);

  // Register selects, shared by the read and the write path
  assign sel_mem_bot0 = (req.addr == CBWD_OFS_MEM_BOT0);
  assign sel_mem_top0 = (req.addr == CBWD_OFS_MEM_TOP0);
  assign sel_mem_bot1 = (req.addr == CBWD_OFS_MEM_BOT1);
  assign sel_mem_top1 = (req.addr == CBWD_OFS_MEM_TOP1);
  assign sel_io_bot0 = (req.addr == CBWD_OFS_IO_BOT0);
  assign sel_io_top0 = (req.addr == CBWD_OFS_IO_TOP0);
  assign sel_io_bot1 = (req.addr == CBWD_OFS_IO_BOT1);
  assign sel_io_top1 = (req.addr == CBWD_OFS_IO_TOP1);
  assign sel_irq_scr = (req.addr == CBWD_OFS_IRQ_SCR);
  assign sel_win_type = (req.addr == CBWD_OFS_WIN_TYPE);

  // Strobes count only while running; a frozen edge drops them
  assign wr_go = clk_en && req.wr;
  assign rd_go = clk_en && req.rd;
  assign we_mem_bot0 = wr_go && sel_mem_bot0;
  assign we_mem_top0 = wr_go && sel_mem_top0;
  assign we_mem_bot1 = wr_go && sel_mem_bot1;
  assign we_mem_top1 = wr_go && sel_mem_top1;
  assign we_io_bot0 = wr_go && sel_io_bot0;
  assign we_io_top0 = wr_go && sel_io_top0;
  assign we_io_bot1 = wr_go && sel_io_bot1;
  assign we_io_top1 = wr_go && sel_io_top1;
  assign we_irq_scr = wr_go && sel_irq_scr;
  assign we_win_type = wr_go && sel_win_type;

  // Narrow registers padded to the bus width for read-back
  assign scr_word = {24'h000000, irq_scr_ff};
  assign type_word = {30'h00000000, win_type_ff};

  // Read decode; unmapped offsets answer zero
  always_comb begin
    nxt_rdata = CBWD_ZERO;
    if (sel_mem_bot0) begin
      nxt_rdata = mem_bot_ff[0];
    end else if (sel_mem_top0) begin
      nxt_rdata = mem_top_ff[0];
    end else if (sel_mem_bot1) begin
      nxt_rdata = mem_bot_ff[1];
    end else if (sel_mem_top1) begin
      nxt_rdata = mem_top_ff[1];
    end else if (sel_io_bot0) begin
      nxt_rdata = io_bot_ff[0];
    end else if (sel_io_top0) begin
      nxt_rdata = io_top_ff[0];
    end else if (sel_io_bot1) begin
      nxt_rdata = io_bot_ff[1];
    end else if (sel_io_top1) begin
      nxt_rdata = io_top_ff[1];
    end else if (sel_irq_scr) begin
      nxt_rdata = scr_word;
    end else if (sel_win_type) begin
      nxt_rdata = type_word;
    end
  end

  // Memory window bottoms; page bits only, low bits never stored
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mem_bot_ff[0] <= CBWD_ZERO;
      mem_bot_ff[1] <= CBWD_ZERO;
    end else begin
      if (we_mem_bot0) begin
        mem_bot_ff[0] <= wmem;
      end
      if (we_mem_bot1) begin
        mem_bot_ff[1] <= wmem;
      end
    end
  end

  // Memory window tops; zero reset keeps both windows closed
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mem_top_ff[0] <= CBWD_ZERO;
      mem_top_ff[1] <= CBWD_ZERO;
    end else begin
      if (we_mem_top0) begin
        mem_top_ff[0] <= wmem;
      end
      if (we_mem_top1) begin
        mem_top_ff[1] <= wmem;
      end
    end
  end

  // I/O window bottoms; dword steps inside the first page
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      io_bot_ff[0] <= CBWD_ZERO;
      io_bot_ff[1] <= CBWD_ZERO;
    end else begin
      if (we_io_bot0) begin
        io_bot_ff[0] <= wio;
      end
      if (we_io_bot1) begin
        io_bot_ff[1] <= wio;
      end
    end
  end

  // I/O window tops; the low two bits are implied at compare time
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      io_top_ff[0] <= CBWD_ZERO;
      io_top_ff[1] <= CBWD_ZERO;
    end else begin
      if (we_io_top0) begin
        io_top_ff[0] <= wio;
      end
      if (we_io_top1) begin
        io_top_ff[1] <= wio;
      end
    end
  end

  // Scratch byte for software; only the read-back path reads it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_scr_ff <= CBWD_IRQ_RST;
    end else if (we_irq_scr) begin
      irq_scr_ff <= req.wdata[7:0];
    end
  end

  // Window type bits; both start prefetchable
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      win_type_ff <= CBWD_TYPE_RST;
    end else if (we_win_type) begin
      win_type_ff <= req.wdata[1:0];
    end
  end

  // Read data stands one cycle, then falls back to zero
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_ff <= CBWD_ZERO;
    end else if (clk_en) begin
      rdata_ff <= rd_go ? nxt_rdata : CBWD_ZERO;
    end
  end

  // Host-side answer, one cycle after the address
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      host_hit_ff <= '0;
    end else if (clk_en) begin
      host_hit_ff <= nxt_host_hit;
    end
  end

  // Card-side answer, one cycle after the address
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      card_hit_ff <= '0;
    end else if (clk_en) begin
      card_hit_ff <= nxt_card_hit;
    end
  end

  // Outputs straight from their flip-flops
  assign rdata = rdata_ff;
  assign host_hit = host_hit_ff;
  assign card_hit = card_hit_ff;
endmodule // cbwd_decode

// ### rtl/cbwd_pkg.sv
// How it works
// - Memory window top registers keep bits 31 to 12 writable, so a top lands on any 4-kbyte page.
// - The low twelve bits of a memory window top read zero and writes to them are dropped.
// - A memory window claims only while its bottom or top value is nonzero, so both start closed.
// - Each memory window is flagged prefetchable or not from its own type bit.
// - Memory window bounds decide both host-to-card and card-to-host forwarding.
// - I/O window bottom bits 31 to 16 and 1 to 0 read zero, fixing the first 64-kbyte page and dword alignment.
// - I/O window bottom bits 15 to 2 are writable and set the window's lowest address.
// - I/O window top bits 15 to 2 are writable and set the window's top on dword steps.
// - I/O window top bits 31 to 16 read zero; the top stays in the first 64-kbyte page, as the bottom does.
// - The two low bits of an I/O top are taken as ones when comparing, so the last dword counts.
// - Writes to read-only bits of the I/O window tops have no effect.
// - An I/O window passes cycles only while its bottom or top is nonzero, so both start closed.
// - I/O window bounds decide both host-to-card and card-to-host forwarding.
// - An eight-bit scratch register resets to all ones, is read and written freely and steers nothing.
// - A type bit of one marks a memory window prefetchable, zero nonprefetchable, and both reset to one.
package cbwd_pkg;
  localparam logic [7:0] CBWD_OFS_MEM_BOT0 = 8'h1c;
  localparam logic [7:0] CBWD_OFS_MEM_TOP0 = 8'h20;
  localparam logic [7:0] CBWD_OFS_MEM_BOT1 = 8'h28;
  localparam logic [7:0] CBWD_OFS_MEM_TOP1 = 8'h24;
  localparam logic [7:0] CBWD_OFS_IO_BOT0 = 8'h2c;
  localparam logic [7:0] CBWD_OFS_IO_TOP0 = 8'h30;
  localparam logic [7:0] CBWD_OFS_IO_BOT1 = 8'h34;
  localparam logic [7:0] CBWD_OFS_IO_TOP1 = 8'h38;
  localparam logic [7:0] CBWD_OFS_IRQ_SCR = 8'h3c;
  localparam logic [7:0] CBWD_OFS_WIN_TYPE = 8'h40;
  localparam logic [31:0] CBWD_MEM_MASK = 32'hffff_f000;
  localparam logic [31:0] CBWD_MEM_LOW_ONES = 32'h0000_0fff;
  localparam logic [31:0] CBWD_IO_MASK = 32'h0000_fffc;
  localparam logic [31:0] CBWD_IO_LOW_ONES = 32'h0000_0003;
  localparam logic [31:0] CBWD_ZERO = 32'h0000_0000;
  localparam logic [7:0] CBWD_IRQ_RST = 8'hff;
  localparam logic [1:0] CBWD_TYPE_RST = 2'h3;
  localparam int CBWD_TYPE_W0 = 0;
  localparam int CBWD_TYPE_W1 = 1;

  // One window's bounds as seen by the compare logic
  typedef struct packed {
    logic [31:0] bottom;
    logic [31:0] top;
  } cbwd_win_t;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } cbwd_req_t;

  // Decode answer for one lookup
  typedef struct packed {
    logic mem_hit;
    logic mem_win;
    logic prefetch;
    logic io_hit;
    logic io_win;
  } cbwd_hit_t;
endpackage

// ### rtl/cbwd_range_cmp.sv
`timescale 1ns/10ps
// Inclusive range check of one window, gated by its open state
module cbwd_range_cmp
  import cbwd_pkg::*;
(
  input wire cbwd_win_t win,
  input wire logic [31:0] low_ones,
  input wire logic [31:0] addr,
  output logic hit
);
  logic open_win;
  logic [31:0] eff_top;

  // Closed while both bounds are zero
  assign open_win = (win.bottom != CBWD_ZERO) || (win.top != CBWD_ZERO);
  assign eff_top = win.top | low_ones;
  assign hit = open_win && (addr >= win.bottom) && (addr <= eff_top);
endmodule // cbwd_range_cmp

// ### verification/cbwd_card_model.sv
`timescale 1ns/10ps
// Card-side initiator, one lookup cycle per call
module cbwd_card_model (
  input wire logic ref_clk,
  output logic [31:0] card_addr,
  output logic card_is_io,
  output logic card_valid
);
  initial card_addr = 32'h0;
  initial card_is_io = 1'b0;
  initial card_valid = 1'b0;
  // Released lines show the inverse, so a stale address cannot hit
  task automatic issue(input logic [31:0] a, input logic io);
    @(posedge ref_clk);
    card_addr <= a;
    card_is_io <= io;
    card_valid <= 1'b1;
    @(posedge ref_clk);
    card_addr <= ~a;
    card_is_io <= ~io;
    card_valid <= 1'b0;
  endtask
endmodule // cbwd_card_model

// ### verification/cbwd_chk_sva.sv
`timescale 1ns/10ps
// Port checks on read data and lookup answers
module cbwd_chk
  import cbwd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire cbwd_req_t req,
  input wire logic [31:0] rdata,
  input wire logic host_valid,
  input wire logic host_is_io,
  input wire cbwd_hit_t host_hit,
  input wire logic card_valid,
  input wire cbwd_hit_t card_hit
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Read-only fields must come back as zero whatever was written
  property p_irq; clk_en && req.rd && req.addr == 8'h3c
    |=> rdata[31:8] == 24'h0; endproperty
  a_irq: assert property (p_irq) else $error("scratch upper bits");
  property p_mlo; clk_en && req.rd && req.addr inside {8'h20, 8'h24}
    |=> rdata[11:0] == 12'h0; endproperty
  a_mlo: assert property (p_mlo) else $error("mem top low bits");
  property p_iro; clk_en && req.rd && req.addr inside {8'h2c, 8'h30,
    8'h34, 8'h38} |=> rdata[31:16] == 16'h0 && rdata[1:0] == 2'h0;
  endproperty
  a_iro: assert property (p_iro) else $error("io ro bits");
  property p_hoff; clk_en && !host_valid |=> host_hit == 5'h0; endproperty
  a_hoff: assert property (p_hoff) else $error("host idle hit");
  property p_coff; clk_en && !card_valid |=> card_hit == 5'h0; endproperty
  a_coff: assert property (p_coff) else $error("card idle hit");
  property p_iom; clk_en && host_valid && host_is_io
    |=> !host_hit.mem_hit && !host_hit.prefetch; endproperty
  a_iom: assert property (p_iom) else $error("io hit memory");
  property p_mio; clk_en && host_valid && !host_is_io
    |=> !host_hit.io_hit && !host_hit.io_win; endproperty
  a_mio: assert property (p_mio) else $error("mem hit io");
  property p_pf; host_hit.prefetch |-> host_hit.mem_hit; endproperty
  a_pf: assert property (p_pf) else $error("stray prefetch");
endmodule // cbwd_chk
bind cbwd_decode cbwd_chk u_chk (.ref_clk, .rst, .clk_en, .req, .rdata,
  .host_valid, .host_is_io, .host_hit, .card_valid, .card_hit);

// ### verification/tb_cardbus_window_decode.sv
`timescale 1ns/10ps
module tb_cardbus_window_decode
  import cbwd_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  cbwd_req_t req = '0;
  logic [31:0] rdata, card_addr, host_addr = 32'h0;
  logic card_is_io, card_valid, host_is_io = 1'b0, host_valid = 1'b0;
  cbwd_hit_t host_hit, card_hit;
  int n_mismatch = 0, num_checks = 0;
  always #4 ref_clk = ~ref_clk;
  cbwd_decode u_dut (.ref_clk, .rst, .clk_en, .req, .rdata,
    .host_addr, .host_is_io, .host_valid, .host_hit, .card_addr,
    .card_is_io, .card_valid, .card_hit);
  cbwd_card_model u_card (.ref_clk, .card_addr, .card_is_io, .card_valid);
  task automatic chk(input logic [31:0] s, e, input string nm);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask
  // Bus cycles: one strobe cycle, then a released cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    req.rd <= 1'b0;
    #1 chk(rdata, e, "rdata");
  endtask
  // Same address looked up from both sides at once
  task automatic lk(input logic [31:0] a, input logic io, input cbwd_hit_t e);
    fork
      u_card.issue(a, io);
      begin
        @(posedge ref_clk);
        {host_addr, host_is_io, host_valid} <= {a, io, 1'b1};
        @(posedge ref_clk);
        {host_addr, host_is_io, host_valid} <= {~a, ~io, 1'b0};
      end
    join
    #1 chk({27'h0, host_hit}, {27'h0, e}, "host_hit");
    chk({27'h0, card_hit}, {27'h0, e}, "card_hit");
  endtask
  task automatic t_regs;
    logic [7:0] ofs [8] = '{8'h20, 8'h24, 8'h2c, 8'h30, 8'h34, 8'h38,
      8'h3c, 8'h40};
    logic [31:0] msk [8] = '{CBWD_MEM_MASK, CBWD_MEM_MASK, CBWD_IO_MASK,
      CBWD_IO_MASK, CBWD_IO_MASK, CBWD_IO_MASK, 32'hff, 32'h3};
    for (int i = 0; i < 8; i++) begin
      rd(ofs[i], i < 6 ? 32'h0 : msk[i]);
      wr(ofs[i], 32'hffff_ffff);
      rd(ofs[i], msk[i]);
      if (i < 6) wr(ofs[i], 32'h0);
    end
    wr(8'h44, 32'hffff_ffff);
    rd(8'h44, 32'h0);
    lk(32'h0, 1'b0, 5'h00);
    lk(32'h0, 1'b1, 5'h00);
    $display("t_regs done");
  endtask
  // Page-granular memory windows, type bits steer prefetch
  task automatic t_mem;
    wr(8'h1c, 32'h1000);
    wr(8'h20, 32'h1000);
    lk(32'h1abc, 1'b0, 5'b10100);
    lk(32'h0ffc, 1'b0, 5'h00);
    lk(32'h2000, 1'b0, 5'h00);
    wr(8'h40, 32'h2);
    lk(32'h1000, 1'b0, 5'b10000);
    wr(8'h24, 32'h3000);
    lk(32'h2ffc, 1'b0, 5'b11100);
    $display("t_mem done");
  endtask
  // Dword windows whose top includes all four bytes of the last dword
  task automatic t_io;
    wr(8'h34, 32'h0100);
    wr(8'h38, 32'h01fc);
    lk(32'h01ff, 1'b1, 5'b00011);
    lk(32'h0200, 1'b1, 5'h00);
    lk(32'h0100, 1'b1, 5'b00011);
    lk(32'h00fc, 1'b1, 5'h00);
    $display("t_io done");
  endtask
  // Frozen cycles drop writes; a mid-run reset restores the scratch byte and closes I/O window 1
  task automatic t_hold;
    wr(8'h3c, 32'h5a);
    rd(8'h3c, 32'h5a);
    @(posedge ref_clk);
    clk_en <= 1'b0;
    wr(8'h3c, 32'h11);
    clk_en <= 1'b1;
    rd(8'h3c, 32'h5a);
    @(posedge ref_clk);
    rst <= 1'b1;
    @(posedge ref_clk);
    rst <= 1'b0;
    rd(8'h3c, 32'hff);
    lk(32'h0100, 1'b1, 5'h00);
    $display("t_hold done");
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs;
    t_mem;
    t_io;
    t_hold;
    close_out;
  end
  // Whole run is a little over a hundred cycles
  initial begin
    repeat (3000) @(posedge ref_clk);
    n_mismatch++;
    close_out;
  end
endmodule // tb_cardbus_window_decode
